// File: design/sadc_ctrl.sv
/*
  control of an 8-bit successive approximation converter: mode and channel
  registers on the cpu byte bus, start delay, sampling, bit decisions and
  result latch with a one-cycle done pulse.
  assumes the analog comparator answers cmp_gt_i (input above tap) and
  cmp_ge_i (input at or above tap) within one clock of tap_o changing, and
  that the cpu bus is synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_ctrl (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [15:0] bus_addr_i,
  input  wire logic       bus_wr_i,
  input  wire logic       bus_rd_i,
  input  wire logic [7:0] bus_wdata_i,
  output logic      [7:0] bus_rdata_o,
  input  wire logic       standby_i,
  input  wire logic       trig_pin_i,
  input  wire logic       cmp_gt_i,
  input  wire logic       cmp_ge_i,
  output logic      [2:0] chan_sel_o,
  output logic            sample_o,
  output logic      [7:0] tap_o,
  output logic      [7:0] result_o,
  output logic            done_irq_o
);
  import sadc_pkg::*;

  sadc_trig_if  trig ();
  sadc_timing_t tim;
  sadc_state_t  state_q;
  sadc_state_t  state_d;
  logic [7:0]   mode_q;
  logic [2:0]   chan_q;
  logic [7:0]   result_q;
  logic [7:0]   sar_q;
  logic [7:0]   sar_d;
  logic [2:0]   bit_q;
  logic [7:0]   cnt_q;
  logic [7:0]   cnt_d;
  logic         armed_q;
  logic         done_q;
  logic [7:0]   rdata_q;
  logic [2:0]   chan_out_q;
  logic         sample_q;

  sadc_trig_edge u_trig (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .trig_pin_i (trig_pin_i),
    .trig       (trig.detector)
  );

  sadc_timing u_timing (
    .time_code_i (mode_q[`SADC_BIT_TIME_HI:`SADC_BIT_TIME_LO]),
    .timing_o    (tim)
  );

  // bus decode
  wire wr_mode_w = bus_wr_i && (bus_addr_i == `SADC_ADDR_MODE);
  wire wr_chan_w = bus_wr_i && (bus_addr_i == `SADC_ADDR_CHAN);
  wire [7:0] mode_d_w = bus_wdata_i & `SADC_MODE_WMASK;

  wire enable_w   = mode_q[`SADC_BIT_ENABLE] & ~standby_i; // RULE_01 RULE_18
  wire hw_mode_w  = mode_q[`SADC_BIT_SOURCE];              // RULE_02
  wire wr_en1_w   = wr_mode_w && mode_d_w[`SADC_BIT_ENABLE];
  // a write of one to enable or any channel write restarts the cycle
  wire restart_w  = wr_chan_w || wr_en1_w;                 // RULE_21 RULE_23
  wire kill_w     = wr_mode_w && !mode_d_w[`SADC_BIT_ENABLE]; // RULE_22
  wire go_w       = hw_mode_w ? trig.edge_seen : armed_q;  // RULE_20
  wire cnt_end_w  = (cnt_q == 8'h00);
  wire last_bit_w = (bit_q == 3'h0);
  wire keep_w     = (bit_q == 3'h7) ? cmp_gt_i : cmp_ge_i;  // RULE_11 RULE_12
  wire finish_w   = (state_q == SADC_DECIDE) && cnt_end_w && last_bit_w;

  assign trig.edge_code = mode_q[`SADC_BIT_EDGE_HI:`SADC_BIT_EDGE_LO];

  wire [7:0] rd_mux_w = (bus_addr_i == `SADC_ADDR_MODE)   ? mode_q :
                        (bus_addr_i == `SADC_ADDR_CHAN)   ? {5'h00, chan_q} : // RULE_07
                        (bus_addr_i == `SADC_ADDR_RESULT) ? result_q : 8'h00;

  // next state; an illegal time code never leaves idle
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sar_d   = sar_q;
    case (state_q)
      SADC_IDLE: begin
        if (enable_w && tim.legal && go_w && !restart_w) begin
          state_d = SADC_DELAY;
          // the armed idle cycle and the zero count are part of the delay
          cnt_d   = tim.delay_clks - 8'h02; // RULE_16
        end
      end
      SADC_DELAY: begin
        if (cnt_end_w) begin
          state_d = SADC_SAMPLE;
          cnt_d   = tim.sample_clks - 8'h01; // RULE_15
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      SADC_SAMPLE: begin
        if (cnt_end_w) begin
          state_d = SADC_DECIDE;
          cnt_d   = tim.bit_clks - 8'h01; // RULE_24
          sar_d   = 8'h80;                // RULE_11
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      SADC_DECIDE: begin
        if (cnt_end_w) begin
          // clear the trial bit when rejected, then trial the next one
          sar_d = sar_q & ~({7'h00, ~keep_w} << bit_q); // RULE_12
          if (!last_bit_w) begin
            sar_d = sar_d | (8'h01 << (bit_q - 3'h1));
            cnt_d = tim.bit_clks - 8'h01;
          end else begin
            // back to back in software mode: restart without the enable delay
            state_d = (hw_mode_w || !enable_w) ? SADC_IDLE : SADC_SAMPLE; // RULE_14
            cnt_d   = tim.sample_clks - 8'h01;
          end
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: state_d = SADC_IDLE;
    endcase
    if (!enable_w || restart_w || kill_w) begin // RULE_01 RULE_22
      state_d = SADC_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= `SADC_MODE_RESET;
      chan_q <= 3'(`SADC_CHAN_RESET); // RULE_08
    end else begin
      if (wr_mode_w) mode_q <= mode_d_w;
      if (wr_chan_w) chan_q <= 3'(bus_wdata_i & `SADC_CHAN_WMASK); // RULE_07
    end
  end

  // software start pends from enable or channel write until taken
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_q <= 1'b0;
    end else if (restart_w) begin
      armed_q <= 1'b1;
    end else if (state_q == SADC_IDLE && state_d == SADC_DELAY) begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= SADC_IDLE;
      cnt_q   <= 8'h00;
      sar_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sar_q   <= sar_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_q <= 3'h7;
    end else if (state_d != SADC_DECIDE) begin
      bit_q <= 3'h7;
    end else if (state_q == SADC_DECIDE && cnt_end_w) begin
      bit_q <= bit_q - 3'h1;
    end
  end

  // partial results are dropped: finish needs a live decide state and no stop, restart or standby in its cycle
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_q <= `SADC_RESULT_RESET; // RULE_09
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (finish_w && enable_w && !restart_w && !kill_w) begin
        result_q <= sar_d;  // RULE_13
        done_q   <= 1'b1;   // RULE_13
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q    <= 8'h00;
      chan_out_q <= 3'h0;
      sample_q   <= 1'b0;
    end else begin
      rdata_q    <= bus_rd_i ? rd_mux_w : 8'h00;
      chan_out_q <= chan_q;
      sample_q   <= (state_d == SADC_SAMPLE); // RULE_10
    end
  end

  assign bus_rdata_o = rdata_q;
  assign chan_sel_o  = chan_out_q;
  assign sample_o    = sample_q;
  assign tap_o       = sar_q;
  assign result_o    = result_q;
  assign done_irq_o  = done_q;
endmodule // sadc_ctrl

// File: design/sadc_params.svh
/*
  constants for the sar converter control: register addresses, field positions,
  reset values and phase timing counts in main clock periods.
  assumes the main clock is ref_clk_i and one cpu clock spans two main clocks.
*/
// How it works
// RULE_01 - enable bit zero halts all conversion
// RULE_02 - source bit: zero software, one trigger
// RULE_03 - time code picks 144..48 clock conversion
// RULE_04 - edge code: none, falling, rising, both
// RULE_05 - software keeps conversion time long enough
// RULE_06 - software stops before changing time code
// RULE_07 - channel register low three bits select
// RULE_08 - reset clears channel register
// RULE_09 - reset clears result register
// RULE_10 - sample input, then hold until done
// RULE_11 - bit seven trial, kept if greater
// RULE_12 - lower bits trial, kept if greater-equal
// RULE_13 - latch result and raise done together
// RULE_14 - conversions repeat until enable cleared; code repeats only in software mode, trigger mode returns to idle
// RULE_15 - sampling length follows the time code
// RULE_16 - start delay after enable, by code
// RULE_17 - software discards first result
// RULE_18 - standby stops the converter
// RULE_19 - software checks done flag before reading
// RULE_20 - each trigger edge starts one conversion; code ignores edges seen while not idle
// RULE_21 - channel write aborts and restarts
// RULE_22 - clearing enable stops, no latch
// RULE_23 - rewriting enable discards and restarts
// RULE_24 - leftover periods split over eight bits
// RULE_25 - trigger edges from synchronised pin samples
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_ADDR_MODE      16'hff80
`define SADC_ADDR_CHAN      16'hff81
`define SADC_ADDR_RESULT    16'hff1f
`define SADC_MODE_RESET     8'h00
`define SADC_CHAN_RESET     8'h00
`define SADC_RESULT_RESET   8'h00
`define SADC_BIT_ENABLE     7
`define SADC_BIT_SOURCE     6
`define SADC_BIT_TIME_HI    5
`define SADC_BIT_TIME_LO    3
`define SADC_BIT_EDGE_HI    2
`define SADC_BIT_EDGE_LO    1
`define SADC_MODE_WMASK     8'hfe
`define SADC_CHAN_WMASK     8'h07
`define SADC_HALF_CPU_CLKS  8'h01
`define SADC_DELAY_SLOW     8'h07
`define SADC_DELAY_FAST     8'h04
`endif

// File: design/sadc_pkg.sv
/*
  types shared by the converter control modules.
  assumes the constants header is included by the modules that need it.
*/
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_EDGE_NONE,
    SADC_EDGE_FALL,
    SADC_EDGE_RISE,
    SADC_EDGE_BOTH
  } sadc_edge_t;
  typedef enum {
    SADC_IDLE,
    SADC_DELAY,
    SADC_SAMPLE,
    SADC_DECIDE
  } sadc_state_t;
  typedef struct packed {
    logic [7:0] conv_clks;
    logic [7:0] sample_clks;
    logic [7:0] bit_clks;
    logic [7:0] delay_clks;
    logic       legal;
  } sadc_timing_t;
endpackage : sadc_pkg

// File: design/sadc_trig_if.sv
/*
  carries the trigger detector's control and event between the modules.
  assumes one clock domain for both ends.
*/
`timescale 1ns/1ps
interface sadc_trig_if;
  logic [1:0] edge_code;
  logic       edge_seen;
  modport detector (input edge_code, output edge_seen);
  modport user     (output edge_code, input edge_seen);
endinterface : sadc_trig_if

// File: design/sadc_trig_edge.sv
/*
  synchroniser and edge detector for the external start trigger.
  assumes the pin is asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module sadc_trig_edge
  import sadc_pkg::*;
(
  input  wire logic    ref_clk_i,
  input  wire logic    reset_n_i,
  input  wire logic    trig_pin_i,
  sadc_trig_if.detector trig
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic seen_q;
  wire  rise_w = sync2_q & ~prev_q;
  wire  fall_w = ~sync2_q & prev_q;
  wire  hit_w  = (trig.edge_code[1] & rise_w) | (trig.edge_code[0] & fall_w); // RULE_04

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      sync1_q <= trig_pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q; // RULE_25
      seen_q  <= hit_w;
    end
  end
  assign trig.edge_seen = seen_q;
endmodule // sadc_trig_edge

// File: design/sadc_timing.sv
/*
  decodes the conversion time code into phase lengths in main clock periods.
  assumes the code is steady while converting; software changes it stopped.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_timing
  import sadc_pkg::*;
(
  input  wire logic [2:0] time_code_i,
  output sadc_timing_t    timing_o
);
  logic [7:0] conv_w;
  logic [7:0] samp_w;
  logic       slow_w;
  always_comb begin
    slow_w = 1'b1;
    case (time_code_i) // RULE_03 RULE_15
      3'h0: begin conv_w = 8'h90; samp_w = 8'h14; end
      3'h1: begin conv_w = 8'h78; samp_w = 8'h10; end
      3'h2: begin conv_w = 8'h60; samp_w = 8'h0c; end
      3'h4: begin conv_w = 8'h48; samp_w = 8'h0a; slow_w = 1'b0; end
      3'h5: begin conv_w = 8'h3c; samp_w = 8'h08; slow_w = 1'b0; end
      3'h6: begin conv_w = 8'h30; samp_w = 8'h06; slow_w = 1'b0; end
      default: begin conv_w = 8'h00; samp_w = 8'h00; end
    endcase
  end
  // delay counted inside conversion time: leftover split over eight bits
  wire [7:0] delay_w = (slow_w ? `SADC_DELAY_SLOW : `SADC_DELAY_FAST) + `SADC_HALF_CPU_CLKS; // RULE_16
  wire [7:0] rest_w  = conv_w - samp_w - delay_w;
  assign timing_o.conv_clks   = conv_w;
  assign timing_o.sample_clks = samp_w;
  assign timing_o.bit_clks    = {3'h0, rest_w[7:3]}; // RULE_24
  assign timing_o.delay_clks  = delay_w;
  assign timing_o.legal       = (conv_w != 8'h00);
endmodule // sadc_timing

// File: sim/sadc_ctrl_checker.sv
/*
  assertions on the converter control ports.
  assumes it is bound onto sadc_ctrl, one clock domain.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_ctrl_checker (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic [7:0]  bus_rdata_o,
  input  wire logic        standby_i,
  input  wire logic [2:0]  chan_sel_o,
  input  wire logic        sample_o,
  input  wire logic [7:0]  tap_o,
  input  wire logic [7:0]  result_o,
  input  wire logic        done_irq_o
);
  logic en_q;
  wire  wr_mode = bus_wr_i && bus_addr_i == `SADC_ADDR_MODE;
  wire  wr_chan = bus_wr_i && bus_addr_i == `SADC_ADDR_CHAN;
  wire  rd_chan = bus_rd_i && bus_addr_i == `SADC_ADDR_CHAN;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // mode register is not a port, so its enable bit is rebuilt from writes
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) en_q <= 1'b0;
    else if (wr_mode) en_q <= bus_wdata_i[`SADC_BIT_ENABLE];
  end
  chk_off_idle: assert property (!en_q [*3] |-> !sample_o && !done_irq_o)
    else $error("converter active while disabled");
  chk_stby_idle: assert property (standby_i [*3] |-> !sample_o && !done_irq_o)
    else $error("converter active in standby");
  chk_done_pulse: assert property (done_irq_o |=> !done_irq_o)
    else $error("done longer than one cycle");
  chk_result_done: assert property ($changed(result_o) |-> done_irq_o)
    else $error("result changed without done");
  chk_sample_min: assert property ($rose(sample_o) |-> (sample_o || standby_i || !en_q) [*6])
    else $error("sampling phase too short");
  chk_msb_trial: assert property ($fell(sample_o) && en_q && !standby_i |-> ##[0:1] tap_o == 8'h80)
    else $error("first trial is not the top bit");
  chk_chan_follow: assert property (wr_chan |-> ##2
    {5'h00, chan_sel_o} == ($past(bus_wdata_i, 2) & `SADC_CHAN_WMASK))
    else $error("channel select does not follow write");
  chk_chan_read: assert property (rd_chan |=> bus_rdata_o[7:3] == 5'h00)
    else $error("channel upper bits not zero");
endmodule // sadc_ctrl_checker

// File: sim/sadc_cmp_model.sv
/*
  behavioural comparator against the sampled input.
  assumes vin_i is held steady for a whole conversion.
*/
`timescale 1ns/1ps
module sadc_cmp_model (
  input  wire logic [7:0] tap_i,
  input  wire logic [7:0] vin_i,
  output logic            gt_o,
  output logic            ge_o
);
  // answers at once, well inside the one clock the design allows
  assign gt_o = vin_i > tap_i;
  assign ge_o = vin_i >= tap_i;
endmodule // sadc_cmp_model

// File: sim/test_sadc_ctrl.sv
/*
  self-checking bench for sadc_ctrl: registers, conversions, aborts, triggers, standby.
  assumes the comparator model stands for the analog side.
*/
`timescale 1ns/1ps
module test_sadc_ctrl;
  logic        ref_clk_i   = 1'b0;
  logic        reset_n_i   = 1'b0;
  logic [15:0] bus_addr_i  = 16'h0000;
  logic        bus_wr_i    = 1'b0;
  logic        bus_rd_i    = 1'b0;
  logic [7:0]  bus_wdata_i = 8'h00;
  logic        standby_i   = 1'b0;
  logic        trig_pin_i  = 1'b0;
  logic [7:0]  vin         = 8'h00;
  logic [7:0]  n_done      = 8'h00;
  logic        cmp_gt, cmp_ge, sample_o, done_irq_o;
  logic [2:0]  chan_sel_o;
  logic [7:0]  bus_rdata_o, tap_o, result_o, rd_v, cnt, n0;
  int          err_total = 0, n_compared = 0, cyc = 0, i;
  // address, write data, expected read back
  localparam logic [31:0] REG_ROWS [0:5] = '{32'hff81ff07, 32'hff810505, 32'hff807f7e, 32'hff800000,
                                             32'hff1faa00, 32'hff825500};
  // input level, expected result
  localparam logic [15:0] CONV_ROWS [0:4] = '{16'h5a5a, 16'h807f, 16'h0000, 16'hffff, 16'h8181};
  // sampling length less its first cycle; zero where the code never starts
  localparam logic [7:0] SAMP [0:7] = '{8'h13, 8'h0f, 8'h0b, 8'h00, 8'h09, 8'h07, 8'h05, 8'h00};
  localparam logic [7:0] EDGES [0:3] = '{8'h00, 8'h01, 8'h01, 8'h02};
  // clocks from enable write to sampling; the wait limit where the code never starts
  localparam logic [7:0] DLY [0:7] = '{8'h08, 8'h08, 8'h08, 8'h28, 8'h05, 8'h05, 8'h05, 8'h28};
  sadc_ctrl sadc_ctrl_i (.ref_clk_i, .reset_n_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_rdata_o,
    .standby_i, .trig_pin_i, .cmp_gt_i(cmp_gt), .cmp_ge_i(cmp_ge), .chan_sel_o, .sample_o, .tap_o,
    .result_o, .done_irq_o);
  sadc_cmp_model sadc_cmp_model_i (.tap_i(tap_o), .vin_i(vin), .gt_o(cmp_gt), .ge_o(cmp_ge));
  always #2.5 ref_clk_i = ~ref_clk_i;
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (done_irq_o === 1'b1) n_done <= n_done + 8'h01;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    bus_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_addr_i <= a;
    bus_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    bus_rd_i <= 1'b0;
    #1 d = bus_rdata_o;
  endtask
  // counts cycles until done or sample reaches v, giving up after n
  task automatic wait_on(input logic on_done, input logic v, input int n, output logic [7:0] c);
    c = 8'h00;
    @(negedge ref_clk_i);
    while (((on_done ? done_irq_o : sample_o) !== v) && c < n) begin
      c = c + 8'h01;
      @(negedge ref_clk_i);
    end
    if (on_done) chk("done seen", {7'h00, done_irq_o}, 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(16'hff81, rd_v);
    chk("channel after reset", rd_v, 8'h00);
    rd(16'hff1f, rd_v);
    chk("result after reset", rd_v, 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(REG_ROWS[i][31:16], REG_ROWS[i][15:8]);
      rd(REG_ROWS[i][31:16], rd_v);
      chk("register read back", rd_v, REG_ROWS[i][7:0]);
    end
    for (i = 0; i < 5; i++) begin
      vin = CONV_ROWS[i][15:8];
      wr(16'hff80, 8'h80);
      wait_on(1'b1, 1'b1, 200, cnt);
      chk("first result", result_o, CONV_ROWS[i][7:0]);
      wait_on(1'b1, 1'b1, 200, cnt);
      chk("repeated result", result_o, CONV_ROWS[i][7:0]);
      chk("conversion length", cnt, 8'h83);
      rd(16'hff1f, rd_v);
      chk("result read", rd_v, CONV_ROWS[i][7:0]);
      wr(16'hff80, 8'h00);
    end
    for (i = 0; i < 8; i++) begin
      wr(16'hff80, {2'b10, 3'(i), 3'b000});
      wait_on(1'b0, 1'b1, 40, cnt);
      chk("start delay", cnt, DLY[i]);
      wait_on(1'b0, 1'b0, 40, cnt);
      chk("sampling length", cnt, SAMP[i]);
      wr(16'hff80, 8'h00);
    end
    vin = 8'h33;
    wr(16'hff80, 8'hb0);
    wait_on(1'b1, 1'b1, 200, cnt);
    for (i = 0; i < 2; i++) begin
      repeat (20) @(posedge ref_clk_i);
      wr(i == 0 ? 16'hff81 : 16'hff80, i == 0 ? 8'h03 : 8'hb0);
      wait_on(1'b1, 1'b1, 200, cnt);
      chk("restart length", {7'h00, cnt >= 8'h1e}, 8'h01);
    end
    chk("channel select", {5'h00, chan_sel_o}, 8'h03);
    repeat (20) @(posedge ref_clk_i);
    n0 = n_done;
    wr(16'hff80, 8'h00);
    repeat (200) @(posedge ref_clk_i);
    chk("done after stop", n_done - n0, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(16'hff80, {5'b11110, 2'(i), 1'b0});
      n0 = n_done;
      repeat (100) @(posedge ref_clk_i);
      trig_pin_i <= 1'b1;
      repeat (100) @(posedge ref_clk_i);
      trig_pin_i <= 1'b0;
      repeat (100) @(posedge ref_clk_i);
      chk("conversions per trigger", n_done - n0, EDGES[i]);
      wr(16'hff80, 8'h00);
    end
    wr(16'hff80, 8'hb0);
    wait_on(1'b0, 1'b1, 40, cnt);
    wait_on(1'b0, 1'b0, 40, cnt);
    @(posedge ref_clk_i);
    standby_i <= 1'b1;
    n0 = n_done;
    repeat (200) @(posedge ref_clk_i);
    chk("done in standby", n_done - n0, 8'h00);
    wr(16'hff80, 8'h00);
    standby_i <= 1'b0;
    wr(16'hff80, 8'hb0);
    wait_on(1'b1, 1'b1, 200, cnt);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    chk("result after mid reset", result_o, 8'h00);
    chk("channel after mid reset", {5'h00, chan_sel_o}, 8'h00);
    rd(16'hff80, rd_v);
    chk("mode after mid reset", rd_v, 8'h00);
    give_verdict();
  end
endmodule // test_sadc_ctrl
bind sadc_ctrl sadc_ctrl_checker sadc_ctrl_checker_i (.ref_clk_i, .reset_n_i, .bus_addr_i, .bus_wr_i, .bus_rd_i,
  .bus_wdata_i, .bus_rdata_o, .standby_i, .chan_sel_o, .sample_o, .tap_o, .result_o, .done_irq_o);
